// file: verilog/edo_cfg.svh
`ifndef EDO_CFG_SVH
`define EDO_CFG_SVH

`define CLK_MHZ 100
`define CYC_UP(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define CYC_DN(ns) (((ns) * `CLK_MHZ) / 1000)

// Figures in ns where the name ends in _NS; _F is the fast grade, _S the slow grade.
`define CYCLE_F_NS 104
`define CYCLE_S_NS 124
`define RPRE_F_NS 40
`define RPRE_S_NS 50
`define COL_HI_BEFORE_ROW_NS 5
`define RCD_MIN_NS 14
`define ROW_HOLD_NS 10
`define RAS_ACC_F_NS 60
`define RAS_ACC_S_NS 70
`define COL_ADDR_ACC_F_NS 30
`define COL_ADDR_ACC_S_NS 35
`define COL_STROBE_ACC_F_NS 15
`define COL_STROBE_ACC_S_NS 18
`define COL_LEAD_F_NS 30
`define COL_LEAD_S_NS 35
`define CAS_PRE_NS 10
`define PAGE_CYCLE_F_NS 25
`define PAGE_CYCLE_S_NS 30
`define FLOAT_F_NS 13
`define FLOAT_S_NS 15
`define RAS_MIN_F_NS 60
`define RAS_MIN_S_NS 70
`define RAS_MAX_NS 10000
`define RAS_PAGE_MAX_NS 125000
`define CBR_SETUP_NS 5
`define CBR_HOLD_NS 10
`define WE_REF_SETUP_NS 10
`define WE_REF_HOLD_NS 15
`define RETENTION_MS 16
`define REFRESH_ROWS 2048
`define SYNC_STAGES 2
`define SAMPLE_MARGIN_CYC 1

`endif

// file: verilog/edo_pkg.sv
package edo_pkg;
    typedef enum logic [2:0] {IDLE, ROW, COL, PGAP, PRE, RCAS, RRAS} st_type;
    typedef logic [13:0] cnt_type;
    typedef logic [10:0] addr_type;
endpackage

// file: verilog/edo_ctrl.sv
`include "edo_cfg.svh"
module edo_ctrl #(
    parameter int RAS_PAGE_MAX_CYC = `CYC_DN(`RAS_PAGE_MAX_NS)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic slow_grade,
    input wire logic req,
    input wire logic req_we,
    input wire edo_pkg::addr_type req_row,
    input wire edo_pkg::addr_type req_col,
    input wire logic [31:0] req_wdata,
    input wire logic [3:0] req_be,
    output logic ack,
    output logic rd_valid,
    output logic [31:0] rd_data,
    output edo_pkg::addr_type mem_addr,
    output logic [1:0] ras_n,
    output logic [3:0] cas_n,
    output logic we_n,
    output logic [31:0] dq_out,
    output logic dq_oe,
    input wire logic [31:0] dq_in
);
    import edo_pkg::*;

    function automatic int mx(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // Counts round minimum times up and maximum times down.
    localparam int ROW_I = mx(`CYC_UP(`RCD_MIN_NS),
        `CYC_UP(`ROW_HOLD_NS));
    localparam int CP_I = `CYC_UP(`CAS_PRE_NS);
    localparam int CRP_I = `CYC_UP(`COL_HI_BEFORE_ROW_NS);
    // One cycle past the synchroniser keeps the sample edge off the
    // very instant at which read data becomes valid.
    localparam int SMP_I = `SYNC_STAGES + `SAMPLE_MARGIN_CYC;
    localparam int AF_I = mx(`CYC_UP(`RAS_ACC_F_NS) - ROW_I,
        `CYC_UP(`COL_ADDR_ACC_F_NS));
    localparam int AS_I = mx(`CYC_UP(`RAS_ACC_S_NS) - ROW_I,
        `CYC_UP(`COL_ADDR_ACC_S_NS));
    localparam int BF_I = mx(`CYC_UP(`COL_STROBE_ACC_F_NS),
        `CYC_UP(`COL_LEAD_F_NS));
    localparam int BS_I = mx(`CYC_UP(`COL_STROBE_ACC_S_NS),
        `CYC_UP(`COL_LEAD_S_NS));
    localparam cnt_type ROW_C = cnt_type'(ROW_I);
    localparam cnt_type CP_C = cnt_type'(CP_I);
    localparam cnt_type COL_F = cnt_type'(mx(mx(AF_I, BF_I) + SMP_I,
        `CYC_UP(`PAGE_CYCLE_F_NS) - CP_I));
    localparam cnt_type COL_S = cnt_type'(mx(mx(AS_I, BS_I) + SMP_I,
        `CYC_UP(`PAGE_CYCLE_S_NS) - CP_I));
    localparam cnt_type PRE_F = cnt_type'(mx(mx(`CYC_UP(`RPRE_F_NS), CRP_I),
        `CYC_UP(`FLOAT_F_NS) + 1));
    localparam cnt_type PRE_S = cnt_type'(mx(mx(`CYC_UP(`RPRE_S_NS), CRP_I),
        `CYC_UP(`FLOAT_S_NS) + 1));
    localparam cnt_type RC_F = cnt_type'(`CYC_UP(`CYCLE_F_NS));
    localparam cnt_type RC_S = cnt_type'(`CYC_UP(`CYCLE_S_NS));
    localparam cnt_type RR_F = cnt_type'(mx(`CYC_UP(`RAS_MIN_F_NS),
        mx(`CYC_UP(`CBR_HOLD_NS), `CYC_UP(`WE_REF_HOLD_NS))));
    localparam cnt_type RR_S = cnt_type'(mx(`CYC_UP(`RAS_MIN_S_NS),
        mx(`CYC_UP(`CBR_HOLD_NS), `CYC_UP(`WE_REF_HOLD_NS))));
    localparam cnt_type CSR_C = cnt_type'(mx(`CYC_UP(`CBR_SETUP_NS),
        `CYC_UP(`WE_REF_SETUP_NS)));
    localparam cnt_type RAS_MAX_C = cnt_type'(`CYC_DN(`RAS_MAX_NS));
    localparam cnt_type PAGE_MAX_C = cnt_type'(RAS_PAGE_MAX_CYC);
    localparam cnt_type REF_INT_C = cnt_type'(`CYC_DN(
        (`RETENTION_MS * 1000000) / `REFRESH_ROWS));

    logic g_s1_q, g_s2_q;
    logic [31:0] dq_s1_q, dq_s2_q;
    st_type st_q, st_d;
    cnt_type cnt_q, cnt_d, since_q, since_d, tmr_q, tmr_d;
    cnt_type col_c, pre_c, rc_c, rr_c;
    addr_type addr_q, addr_d, row_q, row_d, col_q, col_d;
    logic [1:0] ras_q, ras_d;
    logic [3:0] cas_q, cas_d, cas_w, be_q, be_d;
    logic we_q, we_d, oe_q, oe_d, wr_q, wr_d, page_q, page_d;
    logic ack_q, ack_d, rv_q, rv_d, pend_q, pend_d, take_ref, same_page;
    logic [31:0] dq_q, dq_d, rdat_q, rdat_d;

    // The grade strap and the data pins are asynchronous to clk.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            g_s1_q <= 1'b0;
            g_s2_q <= 1'b0;
            dq_s1_q <= 32'h0;
            dq_s2_q <= 32'h0;
        end else begin
            g_s1_q <= slow_grade;
            g_s2_q <= g_s1_q;
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    assign col_c = g_s2_q ? COL_S : COL_F;
    assign pre_c = g_s2_q ? PRE_S : PRE_F;
    assign rc_c = g_s2_q ? RC_S : RC_F;
    assign rr_c = g_s2_q ? RR_S : RR_F;

    // Only enabled lanes strobe on a write; reads strobe every lane.
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_lane
            assign cas_w[i] = wr_q & ~be_q[i];
        end
    endgenerate

    // Page continuation keeps direction, so no read-to-write turnaround
    // inside a page and no early float by write enable pulse is needed.
    assign same_page = req && !pend_q && (req_row == row_q) &&
        (req_we == wr_q) &&
        (since_q + col_c + CP_C + 14'h1 < PAGE_MAX_C);

    always_comb begin
        st_d = st_q;
        cnt_d = (&cnt_q) ? cnt_q : cnt_q + 14'h1;
        since_d = (&since_q) ? since_q : since_q + 14'h1;
        tmr_d = (tmr_q == REF_INT_C - 14'h1) ? 14'h0 : tmr_q + 14'h1;
        addr_d = addr_q;
        row_d = row_q;
        col_d = col_q;
        ras_d = ras_q;
        cas_d = cas_q;
        we_d = we_q;
        oe_d = oe_q;
        wr_d = wr_q;
        be_d = be_q;
        dq_d = dq_q;
        page_d = page_q;
        ack_d = 1'b0;
        rv_d = 1'b0;
        rdat_d = rdat_q;
        take_ref = 1'b0;
        unique case (st_q)
            IDLE: begin
                if (pend_q) begin
                    st_d = RCAS;
                    cas_d = 4'h0;
                    cnt_d = 14'h0;
                end else if (req) begin
                    st_d = ROW;
                    addr_d = req_row;
                    row_d = req_row;
                    col_d = req_col;
                    wr_d = req_we;
                    be_d = req_be;
                    dq_d = req_wdata;
                    ras_d = 2'b00;
                    since_d = 14'h0;
                    cnt_d = 14'h0;
                    ack_d = 1'b1;
                    page_d = 1'b0;
                end
            end
            ROW: begin
                if (req_we_low_ok(wr_q)) begin
                    we_d = 1'b0;
                    oe_d = 1'b1;
                end
                if (cnt_q >= ROW_C - 14'h1) begin
                    st_d = COL;
                    addr_d = col_q;
                    cas_d = cas_w;
                    cnt_d = 14'h0;
                end
            end
            COL: begin
                // Sample point covers the slowest access path plus sync.
                if (cnt_q >= col_c - 14'h1) begin
                    if (!wr_q) begin
                        rv_d = 1'b1;
                        rdat_d = dq_s2_q;
                    end
                    cas_d = 4'hF;
                    if (same_page) begin
                        st_d = PGAP;
                        addr_d = req_col;
                        col_d = req_col;
                        be_d = req_be;
                        dq_d = req_wdata;
                        page_d = 1'b1;
                        ack_d = 1'b1;
                    end else begin
                        st_d = PRE;
                        ras_d = 2'b11;
                        we_d = 1'b1;
                        oe_d = 1'b0;
                    end
                    cnt_d = 14'h0;
                end
            end
            PGAP: begin
                if (cnt_q >= CP_C - 14'h1) begin
                    st_d = COL;
                    cas_d = cas_w;
                    cnt_d = 14'h0;
                end
            end
            PRE: begin
                // Long enough for precharge, output float and cycle time.
                if (cnt_q >= pre_c - 14'h1 && since_q >= rc_c - 14'h1) begin
                    st_d = IDLE;
                end
            end
            RCAS: begin
                if (cnt_q >= CSR_C - 14'h1) begin
                    st_d = RRAS;
                    ras_d = 2'b00;
                    since_d = 14'h0;
                    cnt_d = 14'h0;
                    take_ref = 1'b1;
                    page_d = 1'b0;
                end
            end
            RRAS: begin
                if (cnt_q >= rr_c - 14'h1) begin
                    st_d = PRE;
                    ras_d = 2'b11;
                    cas_d = 4'hF;
                    cnt_d = 14'h0;
                end
            end
        endcase
        // A timer tick in the cycle the refresh is taken is kept.
        pend_d = (tmr_q == REF_INT_C - 14'h1) | (pend_q & ~take_ref);
    end

    function automatic logic req_we_low_ok(input logic w);
        return w;
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // A reset may cut a cycle short, so precharge and cycle
            // spacing are served again before the first access.
            st_q <= PRE;
            cnt_q <= 14'h0;
            since_q <= 14'h0;
            tmr_q <= 14'h0;
            addr_q <= 11'h000;
            row_q <= 11'h000;
            col_q <= 11'h000;
            ras_q <= 2'b11;
            cas_q <= 4'hF;
            we_q <= 1'b1;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
            be_q <= 4'h0;
            dq_q <= 32'h0;
            page_q <= 1'b0;
            ack_q <= 1'b0;
            rv_q <= 1'b0;
            rdat_q <= 32'h0;
            pend_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            since_q <= since_d;
            tmr_q <= tmr_d;
            addr_q <= addr_d;
            row_q <= row_d;
            col_q <= col_d;
            ras_q <= ras_d;
            cas_q <= cas_d;
            we_q <= we_d;
            oe_q <= oe_d;
            wr_q <= wr_d;
            be_q <= be_d;
            dq_q <= dq_d;
            page_q <= page_d;
            ack_q <= ack_d;
            rv_q <= rv_d;
            rdat_q <= rdat_d;
            pend_q <= pend_d;
        end
    end

    assign ack = ack_q;
    assign rd_valid = rv_q;
    assign rd_data = rdat_q;
    assign mem_addr = addr_q;
    assign ras_n = ras_q;
    assign cas_n = cas_q;
    assign we_n = we_q;
    assign dq_out = dq_q;
    assign dq_oe = oe_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    cnt_type hi_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hi_q <= 14'h3FFF;
        end else begin
            hi_q <= !ras_q[0] ? 14'h0 : ((&hi_q) ? hi_q : hi_q + 14'h1);
        end
    end

    property p_rc;
        $fell(ras_q[0]) |-> $past(since_q) >= rc_c - 14'h1;
    endproperty
    a_rc: assert property (p_rc) else $error("cycle spacing short");
    property p_rp;
        $fell(ras_q[0]) |-> $past(hi_q) >= pre_c - 14'h1;
    endproperty
    a_rp: assert property (p_rp) else $error("precharge short");
    property p_crp;
        $fell(ras_q[0]) && (&cas_q) |-> $past(&cas_q);
    endproperty
    a_crp: assert property (p_crp) else $error("cas not high");
    property p_cbr;
        $fell(ras_q[0]) && !(|cas_q) |-> $past(!(|cas_q))
            ##1 !(|cas_q) && we_q;
    endproperty
    a_cbr: assert property (p_cbr) else $error("refresh strobes");
    property p_wdh;
        $rose(cas_q != 4'hF) && oe_q |=> oe_q && $stable(dq_q) && !we_q;
    endproperty
    a_wdh: assert property (p_wdh) else $error("write data hold");
    property p_rdwe;
        (cas_q != 4'hF) && !oe_q |-> we_q;
    endproperty
    a_rdwe: assert property (p_rdwe) else $error("we low in read");
    property p_early;
        $rose(cas_q != 4'hF) && !we_q |-> $past(!we_q) && $past(oe_q);
    endproperty
    a_early: assert property (p_early) else $error("late write");
    property p_rasmax;
        !ras_q[0] && !page_q |-> since_q < RAS_MAX_C;
    endproperty
    a_rasmax: assert property (p_rasmax) else $error("ras long");
    property p_ref;
        $rose(pend_q) |-> ##[1:64] (!pend_q && !ras_q[0] && !(|cas_q));
    endproperty
    a_ref: assert property (p_ref) else $error("refresh late");

    c_read: cover property (rv_q);
    c_write: cover property ($rose(cas_q != 4'hF) && oe_q);
    c_page: cover property (st_q == PGAP);
    c_refresh: cover property (st_q == RRAS);
endmodule

// file: tb/edo_dram_model.sv
`include "edo_cfg.svh"
module edo_dram_model (
    input wire logic slow_grade,
    input wire edo_pkg::addr_type mem_addr,
    input wire logic [1:0] ras_n,
    input wire logic [3:0] cas_n,
    input wire logic we_n,
    input wire logic [31:0] dq,
    output logic [31:0] q,
    output logic q_en,
    output int errs,
    output int refreshes
);
    timeunit 1ns;
    timeprecision 100ps;
    import edo_pkg::*;
    wire ras = ras_n[0];
    wire cas = &cas_n;
    logic [31:0] mem [logic [21:0]];
    logic [31:0] d;
    logic [21:0] k;
    addr_type row_q;
    logic wr = 1'b0;
    logic cbr = 1'b0;
    realtime t_rf = -1.0E4, t_rr = -1.0E4, t_cf = -1.0E4;
    realtime t_cr = -1.0E4, t_wr = -1.0E4, dly;
    initial begin
        errs = 0;
        refreshes = 0;
        q = '0;
        q_en = 1'b0;
    end
    task automatic bad(input string what);
        errs++;
        $display("MISMATCH %s expected legal seen at %0t", what, $realtime);
    endtask
    always @(negedge ras) begin
        if ($realtime - t_rf < (slow_grade ? `CYCLE_S_NS : `CYCLE_F_NS))
            bad("cycle spacing");
        if ($realtime - t_rr < (slow_grade ? `RPRE_S_NS : `RPRE_F_NS))
            bad("row precharge");
        t_rf = $realtime;
        row_q = mem_addr;
        cbr = !cas;
        if (cbr) begin
            refreshes++;
            if ($realtime - t_cf < `CBR_SETUP_NS)
                bad("refresh lead");
            if (!we_n || $realtime - t_wr < `WE_REF_SETUP_NS)
                bad("refresh enable setup");
        end else if ($realtime - t_cr < `COL_HI_BEFORE_ROW_NS)
            bad("column high before row");
    end
    always @(posedge ras) begin
        // The first rise out of an unknown level ends no real low phase.
        if (t_rf > t_rr && $realtime - t_rf > `RAS_MAX_NS)
            bad("row low time");
        if (!cbr && !wr && $realtime - t_cf <
            (slow_grade ? `COL_LEAD_S_NS : `COL_LEAD_F_NS))
            bad("column lead");
        t_rr = $realtime;
    end
    always @(negedge cas) begin
        t_cf = $realtime;
        if (!ras) begin
            k = {row_q, mem_addr};
            wr = !we_n;
            if (!mem.exists(k)) mem[k] = '0;
            d = mem[k];
            if (wr) begin
                for (int i = 0; i < 4; i++)
                    if (!cas_n[i]) d[8*i+:8] = dq[8*i+:8];
                mem[k] = d;
            end else begin
                dly = (slow_grade ? `RAS_ACC_S_NS : `RAS_ACC_F_NS)
                    - ($realtime - t_rf);
                if (dly < (slow_grade ? `COL_STROBE_ACC_S_NS
                    : `COL_STROBE_ACC_F_NS))
                    dly = slow_grade ? `COL_STROBE_ACC_S_NS
                        : `COL_STROBE_ACC_F_NS;
                // Old page data stays for the output hold time, 5 ns.
                if (q_en) q <= #5 ~d;
                else q = ~d;
                q_en = 1'b1;
                q <= #(dly) d;
            end
        end
    end
    always @(posedge cas) t_cr = $realtime;
    always @(posedge ras or posedge cas)
        if (ras && cas)
            q_en <= #(slow_grade ? `FLOAT_S_NS : `FLOAT_F_NS) 1'b0;
    always @(negedge we_n) begin
        if (!wr && !cas && !ras) bad("read enable hold");
        if (cbr && !ras && $realtime - t_rf < `WE_REF_HOLD_NS)
            bad("refresh enable hold");
        if (cas && q_en) q_en <= #(`FLOAT_S_NS) 1'b0;
    end
    always @(posedge we_n) begin
        t_wr = $realtime;
        if (wr && !ras && $realtime - t_cf < 10) bad("write hold");
    end
    always @(dq)
        if (wr && !ras && $realtime - t_cf < 10) bad("data hold");
    always @(posedge cas)
        if (cbr && !ras && $realtime - t_rf < `CBR_HOLD_NS)
            bad("refresh hold");
endmodule

// file: tb/edo_dram_module_timing_test.sv
module edo_dram_module_timing_test;
    timeunit 1ns;
    timeprecision 100ps;
    import edo_pkg::*;
    logic clk, nrst, slow_grade, req, req_we;
    addr_type req_row, req_col, mem_addr;
    logic [31:0] req_wdata, rd_data, dq_out, q, dq, pat;
    logic [3:0] req_be, cas_n;
    logic ack, rd_valid, we_n, dq_oe, q_en;
    logic [1:0] ras_n;
    int n_errors = 0, n_tests = 0, model_errs, refreshes, r0, w;
    logic [31:0] shadow [logic [21:0]];
    logic [31:0] expq [$];
    assign dq = dq_oe === 1'b1 ? dq_out : (q_en ? q : pat);
    edo_ctrl #(.RAS_PAGE_MAX_CYC(40)) u_edo_ctrl (.clk(clk), .nrst(nrst),
        .slow_grade(slow_grade), .req(req), .req_we(req_we),
        .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
        .req_be(req_be), .ack(ack), .rd_valid(rd_valid), .rd_data(rd_data),
        .mem_addr(mem_addr), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq));
    edo_dram_model u_edo_dram_model (.slow_grade(slow_grade),
        .mem_addr(mem_addr), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .dq(dq), .q(q), .q_en(q_en), .errs(model_errs),
        .refreshes(refreshes));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Released bus toggles every cycle so stale data never looks valid.
    initial pat = 32'h3C5A96F0;
    always @(posedge clk) pat <= ~pat;
    task automatic check(input string what, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic complete_run;
        check("model protocol errors", 32'h0, 32'(model_errs));
        $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(negedge clk) begin
        if (dq_oe === 1'b1 && q_en)
            check("bus contention", 32'h0, 32'h1);
        if (rd_valid === 1'b1) begin
            if (expq.size() == 0) check("unexpected read", 32'h0, 32'h1);
            else check("read data", expq.pop_front(), rd_data);
        end
    end
    task automatic access(input logic we, input addr_type row, col,
        input logic [31:0] wd, input logic [3:0] be);
        logic [21:0] k;
        int i;
        k = {row, col};
        req = 1'b1;
        req_we = we;
        req_row = row;
        req_col = col;
        req_wdata = wd;
        req_be = be;
        // Let an edge pass first, so the previous request's ack is not
        // mistaken for this one.
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (ack !== 1'b1 && i < 400);
        if (ack !== 1'b1) begin
            check("ack timeout", 32'h1, 32'h0);
            complete_run();
        end
        if (!we) expq.push_back(shadow[k]);
        else for (i = 0; i < 4; i++)
            if (be[i]) shadow[k][8*i+:8] = wd[8*i+:8];
    endtask
    task automatic idle;
        req = 1'b0;
        @(negedge clk);
    endtask
    // Aligns to a refresh so later windows hold a fixed number of them.
    task automatic wait_refresh;
        r0 = refreshes;
        for (w = 0; w < 800 && refreshes == r0; w++) @(negedge clk);
        check("refresh seen", 32'h1, 32'(refreshes - r0));
        if (w == 800) complete_run();
        r0 = refreshes;
    endtask
    task automatic mixed(input int n, input string name);
        logic we;
        int i;
        for (int j = 0; j < n; j++) begin
            we = 1'($urandom % 2);
            access(we, 11'($urandom % 4), 11'($urandom % 8), $urandom,
                we ? 4'($urandom % 15 + 1) : 4'hF);
            if ($urandom % 3 == 0) idle();
        end
        idle();
        for (i = 0; i < 300 && expq.size() > 0; i++) @(negedge clk);
        check("reads outstanding", 32'h0, 32'(expq.size()));
        if (i == 300) complete_run();
        $display("test %s done", name);
    endtask
    task automatic do_reset;
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        check("idle pins", 32'h3F8, 32'({ras_n, cas_n, we_n, dq_oe, ack,
            rd_valid}));
        expq.delete();
        nrst = 1'b1;
    endtask
    initial begin
        nrst = 1'b0;
        slow_grade = 1'b0;
        req = 1'b0;
        req_we = 1'b0;
        req_row = '0;
        req_col = '0;
        req_wdata = '0;
        req_be = '0;
        void'($urandom(32'h6272));
        do_reset();
        for (int r = 0; r < 4; r++)
            for (int c = 0; c < 8; c++)
                access(1'b1, 11'(r), 11'(c), $urandom, 4'hF);
        idle();
        $display("test fill done");
        mixed(40, "fast grade");
        wait_refresh();
        repeat (1700) @(negedge clk);
        check("refreshes in idle", 32'h2, 32'(refreshes - r0));
        $display("test refresh done");
        slow_grade = 1'b1;
        repeat (4) @(negedge clk);
        mixed(40, "slow grade");
        // Reset lands well clear of any access or refresh in flight.
        wait_refresh();
        repeat (30) @(negedge clk);
        do_reset();
        mixed(20, "after reset");
        complete_run();
    end
    initial begin
        #500000;
        check("run timeout", 32'h1, 32'h0);
        complete_run();
    end
endmodule
